// File: rtl/e3tf_map.svh
// Register indices, field positions, frame layout and reset values of the E3 transmit framer
`ifndef E3TF_MAP_SVH
`define E3TF_MAP_SVH
// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define E3TF_IDX_CFG     8'h30
`define E3TF_IDX_STAT    8'h31
`define E3TF_IDX_MA      8'h36
// ****************************************
// Configuration fields
// ****************************************
`define E3TF_CFG_AUTO    0
`define E3TF_CFG_LOSS    1
`define E3TF_CFG_AIS     2
`define E3TF_CFG_DLNR    4
`define E3TF_CFG_WMASK   8'h17
`define E3TF_CFG_RST     8'h00
// ****************************************
// Maintenance byte fields
// ****************************************
`define E3TF_MA_FAR_END_RECEIVE_FAILURE_BIT     7
`define E3TF_MA_FAR_END_BLOCK_ERROR_BIT     6
`define E3TF_MA_RST      8'h10
// ****************************************
// Frame layout, in byte slots
// ****************************************
`define E3TF_FRAME_BYTES 10'd537
`define E3TF_POS_FA1     10'd0
`define E3TF_POS_FA2     10'd1
`define E3TF_POS_EM      10'd60
`define E3TF_POS_TR      10'd120
`define E3TF_POS_MA      10'd180
`define E3TF_POS_NR      10'd240
`define E3TF_POS_GC      10'd300
`define E3TF_FA1_VAL     8'hF6
`define E3TF_FA2_VAL     8'h28
`define E3TF_FILL        8'hFF
`endif

// File: rtl/e3tf_pkg.sv
// Types shared by the E3 transmit framer
package e3tf_pkg;
    // Overhead input port, level signals held by the source
    typedef struct packed {
        logic       maValid;
        logic [5:0] maLow;
        logic       trValid;
        logic [7:0] tr;
        logic       nrValid;
        logic [7:0] nr;
        logic       gcValid;
        logic [7:0] gc;
    } e3tf_oh_s;
    // Receive framer conditions
    typedef struct packed {
        logic los;
        logic ais;
        logic lof;
        logic bipErr;
    } e3tf_rx_s;
    // Framer state
    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  maReg;
        logic [7:0]  actCfg;
        logic [2:0]  bitCnt;
        logic [9:0]  slot;
        logic [7:0]  sh;
        logic [7:0]  bip;
        logic [7:0]  bipPrev;
        logic        febeHold;
        logic        txData;
        logic        txFrame;
        logic        dlTake;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } e3tf_state_s;
endpackage : e3tf_pkg

// File: rtl/e3tf_framer.sv
// E3 transmit frame assembler with alarm forcing, payload FIFO and APB registers
// What this block does
// (RQ1) Merge payload, overhead and datalink into frames
// (RQ2) Drive serial frame stream to line interface
// (RQ3) Normal mode uses regular overhead and payload sources
// (RQ4) Alarm-indication force sends unframed all ones
// (RQ5) Loss pattern beats alarm-indication pattern
// (RQ6) Loss force zeroes every overhead byte
// (RQ7) Loss force zeroes payload too
// (RQ8) Loss force overrides all other control bits; dlTake still follows DLNR, AUTO still clears febeHold and the payload FIFO is still drained
// (RQ9) Auto select takes far-end bits from receiver
// (RQ10) Software may set far-end bits instead
// (RQ11) Manual mode copies bits from maintenance register
// (RQ12) Auto failure bit set on LOS, AIS, LOF
// (RQ13) Auto block error bit set on parity error
// (RQ14) Control changes apply at frame boundary only
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "e3tf_map.svh"
// ****************************************
// Payload FIFO
// ****************************************
module e3tf_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // Clock and control
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         ce,
    // Fill side
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    // Drain side
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;   // Storage words
        logic [PW-1:0]       wp;    // Write pointer
        logic [PW-1:0]       rp;    // Read pointer
        logic [CW-1:0]       cnt;   // Words held
        logic                rdy;   // Registered not-full
    } e3tf_fifo_s;

    e3tf_fifo_s s;
    e3tf_fifo_s nxt_s;
    logic       push;
    logic       pop;

    assign inReady  = s.rdy;
    assign outValid = (s.cnt != '0);
    assign outData  = s.mem[s.rp];

    // Pointer and count update
    always_comb begin
        nxt_s = s;
        push  = inValid && s.rdy;
        pop   = outReady && (s.cnt != '0);
        if (push) begin
            nxt_s.mem[s.wp] = inData;
            nxt_s.wp = (s.wp == PW'(D - 1)) ? '0 : s.wp + 1'b1;
        end
        if (pop) begin
            nxt_s.rp = (s.rp == PW'(D - 1)) ? '0 : s.rp + 1'b1;
        end
        // Count moves only when exactly one side acts
        if (push && !pop) begin
            nxt_s.cnt = s.cnt + 1'b1;
        end else if (pop && !push) begin
            nxt_s.cnt = s.cnt - 1'b1;
        end
        // Ready is a flop so the source sees a clean level
        nxt_s.rdy = (nxt_s.cnt != CW'(D));
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            s     <= '0;
            s.rdy <= 1'b1;
        end else if (ce) begin
            s <= nxt_s;
        end
    end
endmodule : e3tf_fifo

// ****************************************
// Transmit framer top
// ****************************************
module e3tf_framer
    import e3tf_pkg::*;
(
    // Clock and control
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Payload byte input
    input  wire logic        plValid,
    input  wire logic [7:0]  plData,
    output logic             plReady,
    // Overhead input and datalink controller
    input  wire e3tf_oh_s    ohIn,
    input  wire logic        dlValid,
    input  wire logic [7:0]  dlData,
    output logic             dlTake,
    // Receive framer conditions
    input  wire e3tf_rx_s    rxCond,
    // Line interface
    output logic             txData,
    output logic             txFrame
);
    e3tf_state_s s;         // All framer state
    e3tf_state_s nxt_s;     // Next state
    logic        fifoValid; // Payload byte available
    logic [7:0]  fifoData;  // Head payload byte
    logic        fifoPop;   // Consume head byte
    logic [7:0]  addrIdx;   // Register index from byte address
    logic        idxOk;     // Address word aligned
    logic        mapped;    // Address hits a register
    logic        setupRd;   // Access cycle awaiting answer
    logic        commit;    // Completing edge of access
    logic [31:0] rdMux;     // Read data selection
    logic        lastBit;   // Final bit of a byte slot
    logic [9:0]  nxtSlot;   // Slot about to start
    logic        boundary;  // Next slot opens a frame
    logic [7:0]  useCfg;    // Control in force for next byte
    logic [7:0]  slotByte;  // Byte for next slot
    logic        isMa;      // Next slot is maintenance byte
    logic        ferfBit;   // Far-end failure bit to send
    logic        febeBit;   // Far-end error bit to send

    // Payload buffer; its ready stalls the payload source
    e3tf_fifo #(
        .W (8),
        .D (4)
    ) u_fifo (
        .clock    (clock),
        .rst      (rst),
        .ce       (ce),
        .inValid  (plValid),
        .inData   (plData),
        .inReady  (plReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (fifoPop)
    );

    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;
    assign dlTake  = s.dlTake;
    assign txData  = s.txData;
    assign txFrame = s.txFrame;

    // ****************************************
    // Bus decode
    // ****************************************
    assign addrIdx = {2'b00, paddr[7:2]};
    assign idxOk   = (paddr[1:0] == 2'b00);
    assign mapped  = idxOk && ((addrIdx == `E3TF_IDX_CFG) || (addrIdx == `E3TF_IDX_MA)
                               || (addrIdx == `E3TF_IDX_STAT));
    assign setupRd = psel && penable && !s.pready;
    assign commit  = psel && penable && s.pready;

    // Read data; reserved bits read as zero
    always_comb begin
        rdMux = '0;
        if (idxOk && addrIdx == `E3TF_IDX_CFG) begin
            rdMux[7:0] = s.cfg;
        end else if (idxOk && addrIdx == `E3TF_IDX_MA) begin
            rdMux[7:0] = s.maReg;
        end else if (idxOk && addrIdx == `E3TF_IDX_STAT) begin
            rdMux[7:0] = {3'b000, s.febeHold, ferfBit, s.actCfg[`E3TF_CFG_AIS],
                          s.actCfg[`E3TF_CFG_LOSS], s.actCfg[`E3TF_CFG_AUTO]};
        end
    end

    // ****************************************
    // Frame sequencing
    // ****************************************
    assign lastBit  = (s.bitCnt == 3'd7);
    assign nxtSlot  = (s.slot == `E3TF_FRAME_BYTES - 10'd1) ? 10'd0 : s.slot + 10'd1;
    assign boundary = lastBit && (nxtSlot == 10'd0);
    // New frame picks up the software control word whole
    assign useCfg   = boundary ? s.cfg : s.actCfg; // RQ14
    assign isMa     = (nxtSlot == `E3TF_POS_MA);

    // Far-end indicators, automatic or from software
    always_comb begin
        if (useCfg[`E3TF_CFG_AUTO]) begin // RQ9
            ferfBit = rxCond.los || rxCond.ais || rxCond.lof; // RQ12
            febeBit = s.febeHold || rxCond.bipErr; // RQ13
        end else begin // RQ10
            ferfBit = s.maReg[`E3TF_MA_FAR_END_RECEIVE_FAILURE_BIT]; // RQ11
            febeBit = s.maReg[`E3TF_MA_FAR_END_BLOCK_ERROR_BIT]; // RQ11
        end
    end

    // Byte selection for the coming slot
    always_comb begin
        fifoPop  = 1'b0;
        slotByte = 8'h00;
        case (nxtSlot)
            `E3TF_POS_FA1: slotByte = `E3TF_FA1_VAL;
            `E3TF_POS_FA2: slotByte = `E3TF_FA2_VAL;
            `E3TF_POS_EM:  slotByte = s.bipPrev;
            `E3TF_POS_TR:  slotByte = ohIn.trValid ? ohIn.tr : 8'h00;
            `E3TF_POS_MA:  slotByte = {ferfBit, febeBit, ohIn.maValid ? ohIn.maLow : s.maReg[5:0]};
            `E3TF_POS_NR: begin
                if (useCfg[`E3TF_CFG_DLNR] && dlValid) begin
                    slotByte = dlData;
                end else begin
                    slotByte = ohIn.nrValid ? ohIn.nr : 8'h00;
                end
            end
            `E3TF_POS_GC: begin
                if (!useCfg[`E3TF_CFG_DLNR] && dlValid) begin
                    slotByte = dlData;
                end else begin
                    slotByte = ohIn.gcValid ? ohIn.gc : 8'h00;
                end
            end
            default: begin
                // Payload; an empty buffer sends filler ones
                fifoPop  = lastBit && fifoValid; // RQ3
                slotByte = fifoValid ? fifoData : `E3TF_FILL; // RQ1
            end
        endcase
        // Loss pattern first, so it masks the all-ones force
        if (useCfg[`E3TF_CFG_LOSS]) begin // RQ8
            slotByte = 8'h00; // RQ6 RQ7 RQ5
        end else if (useCfg[`E3TF_CFG_AIS]) begin
            slotByte = 8'hFF; // RQ4
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_s         = s;
        nxt_s.dlTake  = 1'b0;
        nxt_s.txFrame = 1'b0;
        // Bus answer one cycle into the access phase
        if (setupRd) begin
            nxt_s.pready  = 1'b1;
            nxt_s.prdata  = rdMux;
            nxt_s.pslverr = !mapped;
        end else begin
            nxt_s.pready  = 1'b0;
            nxt_s.pslverr = 1'b0;
        end
        // Writes land on the completing edge only
        if (commit && pwrite && idxOk) begin
            if (addrIdx == `E3TF_IDX_CFG) begin
                nxt_s.cfg = pwdata[7:0] & `E3TF_CFG_WMASK;
            end else if (addrIdx == `E3TF_IDX_MA) begin
                nxt_s.maReg = pwdata[7:0];
            end
        end
        // Serial shifter, MSB first
        nxt_s.bitCnt = s.bitCnt + 3'd1;
        if (lastBit) begin
            nxt_s.slot   = nxtSlot;
            nxt_s.actCfg = useCfg;
            nxt_s.sh     = {slotByte[6:0], 1'b0};
            nxt_s.txData = slotByte[7]; // RQ2
            // Frame marker only exists when framing is sent
            nxt_s.txFrame = boundary && !useCfg[`E3TF_CFG_AIS] && !useCfg[`E3TF_CFG_LOSS];
            nxt_s.dlTake = dlValid && (((nxtSlot == `E3TF_POS_NR) && useCfg[`E3TF_CFG_DLNR])
                           || ((nxtSlot == `E3TF_POS_GC) && !useCfg[`E3TF_CFG_DLNR]));
            // Parity over every byte sent in the frame
            if (boundary) begin
                nxt_s.bipPrev = s.bip;
                nxt_s.bip     = slotByte;
            end else begin
                nxt_s.bip = s.bip ^ slotByte;
            end
        end else begin
            nxt_s.sh     = {s.sh[6:0], 1'b0};
            nxt_s.txData = s.sh[7]; // RQ2
        end
        // Parity error held until carried; a new error wins
        if (rxCond.bipErr) begin
            nxt_s.febeHold = 1'b1; // RQ13
        end else if (lastBit && isMa && useCfg[`E3TF_CFG_AUTO]) begin
            nxt_s.febeHold = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            s        <= '0;
            s.cfg    <= `E3TF_CFG_RST;
            s.actCfg <= `E3TF_CFG_RST;
            s.maReg  <= `E3TF_MA_RST;
            s.slot   <= `E3TF_FRAME_BYTES - 10'd1;
        end else if (ce) begin
            s <= nxt_s;
        end
    end
endmodule : e3tf_framer

// File: test/e3tf_framer_checker.sv
// Port assertions of the E3 transmit framer
`timescale 1ns/1ps
module e3tf_framer_checker (
    // Clock and control
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        ce,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Stream side
    input wire logic        plReady,
    input wire logic        dlTake,
    input wire logic        txData,
    input wire logic        txFrame
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ****************************************
    // Bit position since last frame mark
    // ****************************************
    logic [12:0] posBit_ff;  // Index of the bit on the line now
    logic        seen_ff;    // First mark seen
    // Alarm frames carry no mark, so the count runs on by itself
    always_ff @(posedge clock) begin
        if (rst) begin
            posBit_ff <= 13'h0000;
            seen_ff   <= 1'b0;
        end else if (ce) begin
            posBit_ff <= (txFrame || posBit_ff == 13'd4295) ? (txFrame ? 13'd1 : 13'd0) : posBit_ff + 13'd1;
            seen_ff   <= seen_ff | txFrame;
        end
    end
    // ****************************************
    // Sequences
    // ****************************************
    sequence s_setup;  psel && !penable; endsequence
    sequence s_access; psel && penable && !pready; endsequence
    sequence s_align;  txData ##1 txData ##1 txData ##1 txData ##1 !txData ##1 txData ##1 txData ##1 !txData;
    endsequence
    a_apb_answer:   assert property (s_setup ##1 s_access |=> pready) else $error("late bus answer");
    a_ready_pulse:  assert property (pready |=> !pready) else $error("answer held too long");
    a_err_unmapped: assert property (pready && !(paddr inside {8'hC0, 8'hC4, 8'hD8}) |-> pslverr && prdata == 32'h0000)
        else $error("unmapped access not refused");
    a_upper_zero:   assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_align_byte:   assert property (txFrame && ce |-> s_align) else $error("bad first alignment byte");
    a_frame_period: assert property (txFrame && seen_ff |-> posBit_ff == 13'd0) else $error("frame length wrong");
    a_mark_single:  assert property (txFrame |=> !txFrame [*8]) else $error("frame mark too long");
    a_first_frame:  assert property ($fell(rst) |-> ##[1:9] txFrame) else $error("first frame missing");
    a_take_pulse:   assert property (dlTake |=> !dlTake [*8]) else $error("datalink take repeated");
    a_reset_quiet:  assert property (disable iff (1'b0) rst |=> !pready && !dlTake && !txFrame && plReady)
        else $error("outputs active in reset");
endmodule : e3tf_framer_checker
bind e3tf_framer e3tf_framer_checker u_chk (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .plReady(plReady), .dlTake(dlTake),
    .txData(txData), .txFrame(txFrame));

// File: test/e3tf_line_rx.sv
// Line interface receiver model: recovers bytes from the serial stream
`timescale 1ns/1ps
module e3tf_line_rx (
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rst,
    input  wire logic  ce,
    // Line from the framer
    input  wire logic  txData,
    input  wire logic  txFrame,
    // Recovered bytes
    output logic       byteStb,
    output logic [7:0] byteVal,
    output logic [9:0] byteIdx,
    output logic       frameMark
);
    logic [12:0] bitIdx;  // Bit position in frame
    logic        run;     // Locked after first mark
    logic [7:0]  sh;      // Shift register, MSB first
    // Own count keeps alignment through unframed alarm frames
    always_ff @(posedge clock) begin
        logic [12:0] b;
        b = txFrame ? 13'd0 : bitIdx;
        byteStb <= 1'b0;
        if (rst) begin
            run    <= 1'b0;
            bitIdx <= 13'd0;
        end else if (ce && (run || txFrame)) begin
            run <= 1'b1;
            sh  <= {sh[6:0], txData};
            if (b == 13'd0) frameMark <= txFrame;
            if (b[2:0] == 3'd7) begin
                byteStb <= 1'b1;
                byteVal <= {sh[6:0], txData};
                byteIdx <= b[12:3];
            end
            bitIdx <= (b == 13'd4295) ? 13'd0 : b + 13'd1;
        end
    end
endmodule : e3tf_line_rx

// File: test/test_e3tf_framer.sv
// Self-checking bench of the E3 transmit framer
`timescale 1ns/1ps
module test_e3tf_framer;
    import e3tf_pkg::*;
    logic clock, rst, ce, psel, penable, pwrite, pready, pslverr, plValid, plReady, dlValid, dlTake;
    logic txData, txFrame, byteStb, frameMark, hold, er;
    logic [7:0] paddr, plData, dlData, byteVal, cfgW, act, maint, emAcc, emPrev, dlLast, expB;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] byteIdx;
    e3tf_oh_s ohIn;
    e3tf_rx_s rxCond;
    logic [7:0] pq[$];  // Payload bytes handed to the FIFO
    logic [7:0] modes[8] = '{8'h00, 8'h01, 8'h11, 8'h04, 8'h06, 8'h02, 8'h17, 8'h00};
    int mismatches, tests_run, cycles;
    e3tf_framer i_dut (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .plValid(plValid),
        .plData(plData), .plReady(plReady), .ohIn(ohIn), .dlValid(dlValid), .dlData(dlData), .dlTake(dlTake),
        .rxCond(rxCond), .txData(txData), .txFrame(txFrame));
    e3tf_line_rx i_line (.clock(clock), .rst(rst), .ce(ce), .txData(txData), .txFrame(txFrame), .byteStb(byteStb),
        .byteVal(byteVal), .byteIdx(byteIdx), .frameMark(frameMark));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ****************************************
    // Compare, bus and wait tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task chkByte(input logic [7:0] got, input logic [7:0] exp);
        chk({24'h0, got}, {24'h0, exp});
    endtask : chkByte
    task finish_test;
        if (mismatches == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // One bus transfer, then an idle cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task rdChk(input logic [7:0] a, input logic [7:0] e, input logic ee);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, {24'h0, e});
        chk({31'h0, er}, {31'h0, ee});
    endtask : rdChk
    task waitIdx(input int n);
        do @(posedge clock); while (!(byteStb === 1'b1 && byteIdx == 10'(n)));
    endtask : waitIdx
    // ****************************************
    // Sources and the reference model
    // ****************************************
    always @(posedge clock) begin
        cycles++;
        if (!rst && ce && plValid && plReady === 1'b1) begin pq.push_back(plData); plData <= 8'($urandom); end
        if (ce && dlTake === 1'b1) begin dlLast = dlData; dlData <= 8'($urandom); end
        if (cycles == 60000) begin mismatches++; finish_test(); end
    end
    // Mode latches at frame start; every received byte is predicted
    always @(posedge clock) if (byteStb === 1'b1) begin
        if (byteIdx == 10'd0) act = cfgW;
        case (byteIdx)
            10'd0:   expB = 8'hF6;
            10'd1:   expB = 8'h28;
            10'd60:  expB = emPrev;
            10'd120: expB = ohIn.tr;
            10'd180: begin
                expB[7:6] = act[0] ? {rxCond.los | rxCond.ais | rxCond.lof, hold} : maint[7:6];
                expB[5:0] = ohIn.maValid ? ohIn.maLow : maint[5:0];
                if (act[0]) hold = 1'b0;
            end
            10'd240: expB = act[4] ? dlLast : (ohIn.nrValid ? ohIn.nr : 8'h00);
            10'd300: expB = act[4] ? (ohIn.gcValid ? ohIn.gc : 8'h00) : dlLast;
            default: expB = (pq.size() > 0) ? pq.pop_front() : 8'hFF;
        endcase
        if (act[1]) expB = 8'h00;
        else if (act[2]) expB = 8'hFF;
        chkByte(byteVal, expB);
        if (byteIdx == 10'd0) chkByte({7'h0, frameMark}, {7'h0, !(act[1] | act[2])});
        emAcc = emAcc ^ byteVal;
        if (byteIdx == 10'd536) begin emPrev = emAcc; emAcc = 8'h00; end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        plValid = 1'b0; plData = 8'h00; dlValid = 1'b1; dlData = 8'h5A; rxCond = '0; ohIn = '0;
        mismatches = 0; tests_run = 0; cycles = 0; cfgW = 8'h00; act = 8'h00; maint = 8'h10;
        emAcc = 8'h00; emPrev = 8'h00; dlLast = 8'h00; hold = 1'b0;
        void'($urandom(32'h656a));
        ohIn.trValid = 1'b1;
        ohIn.tr = 8'($urandom);
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        plValid <= 1'b1;
        @(posedge clock);
        rdChk(8'hC0, 8'h00, 1'b0);
        rdChk(8'hD8, 8'h10, 1'b0);
        rdChk(8'h04, 8'h00, 1'b1);
        rdChk(8'hC1, 8'h00, 1'b1);
        for (int p = 0; p < 8; p++) begin
            waitIdx(100);
            rdChk(8'hC4, {3'b000, hold, act[0] ? |rxCond[3:1] : maint[7], act[2:0]}, 1'b0);
            apb(1'b1, 8'hC0, 32'hFFFF_FFFF);
            rdChk(8'hC0, 8'h17, 1'b0);
            apb(1'b1, 8'hC0, {24'h0, modes[p]});
            cfgW = modes[p];
            rd = $urandom;
            maint = rd[7:0];
            apb(1'b1, 8'hD8, rd);
            rdChk(8'hD8, maint, 1'b0);
            ohIn <= {p[1], 6'($urandom), 1'b1, 8'($urandom), p[0], 8'($urandom), p[2], 8'($urandom)};
            rxCond <= {3'($urandom), p == 1};
            @(posedge clock);
            rxCond.bipErr <= 1'b0;
            if (p == 1) hold = 1'b1;
            if (p == 3) begin ce <= 1'b0; repeat (5) @(posedge clock); ce <= 1'b1; end
            if (p == 7) plValid <= 1'b0;
            waitIdx(0);
        end
        waitIdx(0);
        plValid <= 1'b1;
        waitIdx(536);
        finish_test();
    end
endmodule : test_e3tf_framer
